// [rtl/crs_pkg.sv]
// Package for the core register state and accumulator saturation block
// Assumes a single core clock domain and a plain register port
package crs_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int CRS_WREG_COUNT = 16;
	localparam int CRS_ACC_W = 40;
	localparam int CRS_PC_W = 23;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] CRS_SP_RESET = 16'h0800;
	localparam logic [15:0] CRS_STATUS_RESET = 16'h0000;
	localparam logic [3:0] CRS_SP_INDEX = 4'hF;
	// ----------------------------------------
	// Register map, byte addresses (word aligned)
	// ----------------------------------------
	localparam logic [7:0] CRS_OFF_WREG0 = 8'h00; // Working registers 0x00..0x1E
	localparam logic [7:0] CRS_OFF_STATUS = 8'h20;
	localparam logic [7:0] CRS_OFF_PCL = 8'h22;
	localparam logic [7:0] CRS_OFF_PCH = 8'h24;
	localparam logic [7:0] CRS_OFF_ACCUMULATOR_A_L = 8'h26; // Each accumulator takes three words
	localparam logic [7:0] CRS_OFF_ACCUMULATOR_B_L = 8'h2C;
	localparam logic [7:0] CRS_OFF_LOOP_START = 8'h32;
	localparam logic [7:0] CRS_OFF_LOOP_END = 8'h34;
	localparam logic [7:0] CRS_OFF_LOOP_COUNT = 8'h36;
	// ----------------------------------------
	// Status register bit positions
	// ----------------------------------------
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_OV = 2;
	localparam int SR_N = 3;
	localparam int SR_RA = 4;
	localparam int SR_IPL0 = 5; // Priority level in bits 7:5
	localparam int SR_DC = 8;
	localparam int SR_DA = 9;
	localparam int SR_SAB = 10;
	localparam int SR_OAB = 11;
	localparam int SR_SB = 12;
	localparam int SR_SA = 13;
	localparam int SR_OB = 14;
	localparam int SR_OA = 15;
	localparam logic [15:0] CRS_SHADOW_MASK = 16'h010F; // DC, N, OV, Z, C
	// ----------------------------------------
	// Saturation limits
	// ----------------------------------------
	localparam logic [39:0] CRS_MAX_931 = 40'h7FFFFFFFFF;
	localparam logic [39:0] CRS_MIN_931 = 40'h8000000000;
	localparam logic [39:0] CRS_MAX_131 = 40'h007FFFFFFF;
	localparam logic [39:0] CRS_MIN_131 = 40'hFF80000000;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic sel;        // 0 = accumulator_a, 1 = accumulator_b
		logic [40:0] sum; // Adder result with one extra sign bit
	} crs_accop_s;
	typedef struct packed {
		logic [15:0] start;
		logic [15:0] stop;
		logic [15:0] count;
	} crs_loop_s;
	typedef enum logic [2:0] {
		CRS_MODE_CAT = 3'b001,
		CRS_MODE_S31 = 3'b010,
		CRS_MODE_S39 = 3'b100
	} crs_mode_e;
endpackage

// [rtl/crs_core_state.sv]
// Architectural register state and accumulator overflow/saturation logic
// Assumes decode/execute logic drives one-cycle event strobes on mclk
`timescale 1ns/1ns
//
// Operation
// [RL1] Sixteen 16-bit registers, two 40-bit accumulators mapped
// [RL2] Push/pop shadow W0-W3 and five flags
// [RL3] Loop registers shadowed on loop start/end
// [RL4] Shadows never directly readable or writable
// [RL5] Byte operation changes only low byte
// [RL6] Register fifteen is auto-updated stack pointer
// [RL7] Stack pointer resets to 0x0800, bit0 zero
// [RL8] Low status byte: flags, priority, repeat
// [RL9] Exception pushes status low with PC top
// [RL10] High status byte: DSP flags, loop, digit-carry
// [RL11] 23-bit program counter, bit 0 zero
// [RL12] Saturation flags sticky, cleared only by software
// [RL13] Overflow at bit 31 or 39 per width
// [RL14] Trap when enabled, saturation off, flag set
// [RL15] Combined overflow and saturation bits are ORs
// [RL16] Bit-39 mode clamps to 9.31 limits
// [RL17] Bit-31 mode clamps to sign-extended 1.31 limits
// [RL18] Bit-31 mode never sets overflow flags
// [RL19] Catastrophic mode wraps, still sets flag
// [RL20] Saturation config sampled per accumulator write
module crs_core_state
	import crs_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	// Execute-side working register write
	input wire logic wregWr,
	input wire logic wregByte,
	input wire logic [3:0] wregSel,
	input wire logic [15:0] wregData,
	// Stack pointer adjust and program counter load
	input wire logic spAdjust,
	input wire logic [15:0] spDelta,
	input wire logic pcLoad,
	input wire logic [22:0] pcNext,
	// Status updates from execute
	input wire logic flagWr,
	input wire logic [7:0] flagLow,
	input wire logic loopActive,
	// Shadow and loop events
	input wire logic pushShadow,
	input wire logic popShadow,
	input wire logic loopBegin,
	input wire logic loopEnd,
	input wire crs_loop_s loopNew,
	// Accumulator operation and configuration
	input wire crs_accop_s accOp,
	input wire logic satEnable,
	input wire logic satWidth31,
	input wire logic catastrophicTrapEnable,
	// Outputs
	output logic [15:0] coreStatus,
	output logic [22:0] programCounter,
	output logic [15:0] stackPointer,
	output logic [15:0] exceptionWord,
	output logic [39:0] accumulatorA,
	output logic [39:0] accumulatorB,
	output crs_loop_s loopRegs,
	output logic arithmeticTrap
);
	logic [15:0] wreg [CRS_WREG_COUNT];
	logic [15:0] shadowW [4];
	logic [15:0] shadowFlags;
	crs_loop_s shadowLoop;
	logic [39:0] acc [2];
	logic [7:0] statusLow;
	logic dcFlag, daFlag;
	logic [1:0] satFlag, ovfFlag;
	crs_mode_e mode;
	logic [39:0] next_acc;
	logic next_sat, next_ovf;
	logic swWr;
	logic accIdx;
	logic [7:0] accRel;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Byte-aware merge of a 16-bit value
	function automatic logic [15:0] mergeByte(input logic [15:0] old, input logic [15:0] val,
		input logic byteOp);
		mergeByte = byteOp ? {old[15:8], val[7:0]} : val;
	endfunction

	// Mode decode, sampled with each accumulator write
	always_comb begin
		if (!satEnable) begin
			mode = CRS_MODE_CAT;
		end else if (satWidth31) begin
			mode = CRS_MODE_S31;
		end else begin
			mode = CRS_MODE_S39;
		end // [RL20]
	end

	assign swWr = regWr && (regAddr < CRS_OFF_STATUS);

	// Accumulator and word select for the register port
	assign accIdx = regAddr >= CRS_OFF_ACCUMULATOR_B_L;
	assign accRel = regAddr - (accIdx ? CRS_OFF_ACCUMULATOR_B_L : CRS_OFF_ACCUMULATOR_A_L);

	// ----------------------------------------
	// Working registers
	// ----------------------------------------
	// Software, execute and shadow writes; stack pointer bit 0 forced clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < CRS_WREG_COUNT; i++) begin
				wreg[i] <= 16'h0000;
			end
			wreg[CRS_SP_INDEX] <= CRS_SP_RESET; // [RL7]
		end else begin
			if (swWr) begin
				wreg[regAddr[4:1]] <= regWdata & ((regAddr[4:1] == CRS_SP_INDEX) ? 16'hFFFE : 16'hFFFF); // [RL1]
			end
			if (wregWr) begin
				wreg[wregSel] <= mergeByte(wreg[wregSel], wregData, wregByte) &
					((wregSel == CRS_SP_INDEX) ? 16'hFFFE : 16'hFFFF); // [RL5] [RL7]
			end
			if (spAdjust) begin
				wreg[CRS_SP_INDEX] <= (wreg[CRS_SP_INDEX] + spDelta) & 16'hFFFE; // [RL6]
			end
			if (popShadow) begin
				for (int i = 0; i < 4; i++) begin
					wreg[i] <= shadowW[i]; // [RL2]
				end
			end
		end
	end

	// Shadows: only reachable by transfer events
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				shadowW[i] <= 16'h0000;
			end
			shadowFlags <= 16'h0000;
		end else if (pushShadow) begin
			for (int i = 0; i < 4; i++) begin
				shadowW[i] <= wreg[i]; // [RL2] [RL4]
			end
			shadowFlags <= coreStatus & CRS_SHADOW_MASK;
		end
	end

	// Loop registers and their shadows
	always_ff @(posedge mclk) begin
		if (rst) begin
			loopRegs <= '0;
			shadowLoop <= '0;
		end else if (loopBegin) begin
			shadowLoop <= loopRegs; // [RL3]
			loopRegs <= loopNew;
		end else if (loopEnd) begin
			loopRegs <= shadowLoop; // [RL3]
		end else if (regWr && regAddr == CRS_OFF_LOOP_START) begin
			loopRegs.start <= regWdata;
		end else if (regWr && regAddr == CRS_OFF_LOOP_END) begin
			loopRegs.stop <= regWdata;
		end else if (regWr && regAddr == CRS_OFF_LOOP_COUNT) begin
			loopRegs.count <= regWdata;
		end
	end

	// ----------------------------------------
	// Status register
	// ----------------------------------------
	// Low byte flags, priority, repeat; digit-carry and loop flag above
	always_ff @(posedge mclk) begin
		if (rst) begin
			statusLow <= CRS_STATUS_RESET[7:0];
			dcFlag <= 1'b0;
			daFlag <= 1'b0;
		end else begin
			daFlag <= loopActive; // [RL10]
			if (popShadow) begin
				statusLow[3:0] <= shadowFlags[3:0]; // [RL2]
				dcFlag <= shadowFlags[SR_DC];
			end else if (regWr && regAddr == CRS_OFF_STATUS) begin
				statusLow <= regWdata[7:0]; // [RL8]
				dcFlag <= regWdata[SR_DC];
			end else if (flagWr) begin
				statusLow <= flagLow; // [RL8]
			end
		end
	end

	// ----------------------------------------
	// Accumulator saturation
	// ----------------------------------------
	// Detect overflow and pick the written value per mode
	always_comb begin
		logic ov39, ov31;
		ov39 = accOp.sum[40] ^ accOp.sum[39];
		ov31 = accOp.sum[40] != accOp.sum[31] || accOp.sum[39:31] != {9{accOp.sum[31]}};
		next_acc = accOp.sum[39:0];
		next_sat = 1'b0;
		next_ovf = 1'b0;
		unique case (mode)
			CRS_MODE_S39: begin
				next_ovf = accOp.sum[39:31] != {9{accOp.sum[39]}};
				if (ov39) begin
					next_acc = accOp.sum[40] ? CRS_MIN_931 : CRS_MAX_931; // [RL16]
					next_sat = 1'b1;
				end
			end
			CRS_MODE_S31: begin
				if (ov31) begin
					next_acc = accOp.sum[40] ? CRS_MIN_131 : CRS_MAX_131; // [RL17]
					next_sat = 1'b1;
				end // [RL18]
			end
			CRS_MODE_CAT: begin
				next_sat = ov39; // [RL19] [RL13]
				next_ovf = accOp.sum[39:31] != {9{accOp.sum[39]}};
			end
		endcase
	end

	// Accumulators, software-mapped as three words each
	always_ff @(posedge mclk) begin
		if (rst) begin
			acc[0] <= 40'h0000000000;
			acc[1] <= 40'h0000000000;
		end else if (accOp.valid) begin
			acc[accOp.sel] <= next_acc;
		end else if (regWr && regAddr >= CRS_OFF_ACCUMULATOR_A_L && regAddr < CRS_OFF_LOOP_START) begin
			unique case (accRel)
				8'h00: acc[accIdx][15:0] <= regWdata; // [RL1]
				8'h02: acc[accIdx][31:16] <= regWdata;
				default: acc[accIdx][39:32] <= regWdata[7:0];
			endcase
		end
	end

	// Sticky saturation flags: hardware set wins over software clear; overflow flags reload on each accumulator op
	always_ff @(posedge mclk) begin
		if (rst) begin
			satFlag <= 2'b00;
			ovfFlag <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (accOp.valid && accOp.sel == i[0] && next_sat) begin
					satFlag[i] <= 1'b1; // [RL12]
				end else if (regWr && regAddr == CRS_OFF_STATUS && !regWdata[SR_SA - i]) begin
					satFlag[i] <= 1'b0; // [RL12]
				end
				if (accOp.valid && accOp.sel == i[0]) begin
					ovfFlag[i] <= next_ovf; // [RL18]
				end
			end
		end
	end

	assign arithmeticTrap = catastrophicTrapEnable && !satEnable && |satFlag; // [RL14]

	// ----------------------------------------
	// Program counter
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			programCounter <= 23'h000000;
		end else if (pcLoad) begin
			programCounter <= {pcNext[22:1], 1'b0}; // [RL11]
		end
	end

	// ----------------------------------------
	// Outputs and read port
	// ----------------------------------------
	assign coreStatus = {ovfFlag[0], ovfFlag[1], satFlag[0], satFlag[1],
		|ovfFlag, |satFlag, daFlag, dcFlag, statusLow}; // [RL15] [RL10] [RL8]
	assign exceptionWord = {statusLow, 1'b0, programCounter[22:16]}; // [RL9]
	assign stackPointer = wreg[CRS_SP_INDEX]; // [RL6]
	assign accumulatorA = acc[0];
	assign accumulatorB = acc[1];

	// Registered read data, shadows have no address
	always_ff @(posedge mclk) begin
		if (rst) begin
			regRdata <= 16'h0000;
		end else if (regRd) begin
			if (regAddr < CRS_OFF_STATUS) begin
				regRdata <= wreg[regAddr[4:1]]; // [RL4]
			end else begin
				unique case (regAddr)
					CRS_OFF_STATUS: regRdata <= coreStatus;
					CRS_OFF_PCL: regRdata <= programCounter[15:0];
					CRS_OFF_PCH: regRdata <= {9'h000, programCounter[22:16]};
					CRS_OFF_ACCUMULATOR_A_L: regRdata <= acc[0][15:0];
					8'h28: regRdata <= acc[0][31:16];
					8'h2A: regRdata <= {8'h00, acc[0][39:32]};
					CRS_OFF_ACCUMULATOR_B_L: regRdata <= acc[1][15:0];
					8'h2E: regRdata <= acc[1][31:16];
					8'h30: regRdata <= {8'h00, acc[1][39:32]};
					CRS_OFF_LOOP_START: regRdata <= loopRegs.start;
					CRS_OFF_LOOP_END: regRdata <= loopRegs.stop;
					CRS_OFF_LOOP_COUNT: regRdata <= loopRegs.count;
					default: regRdata <= 16'h0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_sp_reset;
		@(posedge mclk) rst |=> stackPointer == CRS_SP_RESET;
	endproperty
	a_sp_reset: assert property (p_sp_reset) else $error("stack pointer reset wrong"); // [RL7]
	property p_sp_align;
		@(posedge mclk) disable iff (rst) stackPointer[0] == 1'b0;
	endproperty
	a_sp_align: assert property (p_sp_align) else $error("stack pointer odd"); // [RL7]
	property p_pc_align;
		@(posedge mclk) disable iff (rst) programCounter[0] == 1'b0;
	endproperty
	a_pc_align: assert property (p_pc_align) else $error("program counter odd"); // [RL11]
	property p_sticky;
		@(posedge mclk) disable iff (rst)
			satFlag[0] && !(regWr && regAddr == CRS_OFF_STATUS && !regWdata[SR_SA])
			|=> satFlag[0];
	endproperty
	a_sticky: assert property (p_sticky) else $error("saturation flag dropped"); // [RL12]
	property p_comb;
		@(posedge mclk) disable iff (rst)
			coreStatus[SR_SAB] == (coreStatus[SR_SA] | coreStatus[SR_SB]);
	endproperty
	a_comb: assert property (p_comb) else $error("combined bit wrong"); // [RL15]
	property p_s39;
		@(posedge mclk) disable iff (rst) accOp.valid && !accOp.sel && mode == CRS_MODE_S39
			&& !accOp.sum[40] && accOp.sum[39] |=> accumulatorA == CRS_MAX_931 && satFlag[0];
	endproperty
	a_s39: assert property (p_s39) else $error("bit-39 clamp wrong"); // [RL16]
	property p_s39_neg;
		@(posedge mclk) disable iff (rst) accOp.valid && accOp.sel && mode == CRS_MODE_S39
			&& accOp.sum[40] && !accOp.sum[39] |=> accumulatorB == CRS_MIN_931 && satFlag[1];
	endproperty
	a_s39_neg: assert property (p_s39_neg) else $error("bit-39 negative clamp wrong"); // [RL16]
	property p_cat_wrap;
		@(posedge mclk) disable iff (rst) accOp.valid && !accOp.sel && mode == CRS_MODE_CAT
			|=> accumulatorA == $past(accOp.sum[39:0]);
	endproperty
	a_cat_wrap: assert property (p_cat_wrap) else $error("catastrophic mode clamped"); // [RL19]
	property p_s31_ovf;
		@(posedge mclk) disable iff (rst) accOp.valid && mode == CRS_MODE_S31
			|=> ovfFlag[$past(accOp.sel)] == 1'b0;
	endproperty
	a_s31_ovf: assert property (p_s31_ovf) else $error("overflow set in 31 mode"); // [RL18]
	property p_trap;
		@(posedge mclk) disable iff (rst)
			arithmeticTrap == (catastrophicTrapEnable && !satEnable && coreStatus[SR_SAB]);
	endproperty
	a_trap: assert property (p_trap) else $error("spurious trap"); // [RL14]
	property p_pop;
		@(posedge mclk) disable iff (rst) pushShadow ##1 (!pushShadow && !wregWr) [*1] ##0 popShadow
			|=> wreg[0] == $past(wreg[0], 2);
	endproperty
	a_pop: assert property (p_pop) else $error("shadow restore wrong"); // [RL2]
	c_sat: cover property (@(posedge mclk) disable iff (rst) $rose(satFlag[1]));
	c_trap: cover property (@(posedge mclk) disable iff (rst) $rose(arithmeticTrap));
	c_loop: cover property (@(posedge mclk) disable iff (rst) loopBegin ##[1:20] loopEnd);
endmodule

// [dv/crs_exec_model.sv]
// Execute-side model issuing accumulator adder results
// Assumes calls are made right after a rising mclk edge
`timescale 1ns/1ns
module crs_exec_model
	import crs_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Adder result and saturation configuration
	output crs_accop_s accOp,
	output logic satEnable,
	output logic satWidth31
);
	initial begin
		accOp = '0;
		satEnable = 1'b0;
		satWidth31 = 1'b0;
	end
	// One adder result after an optional stall; idle bus shows inverted data
	task automatic issue(input logic sel, input logic [40:0] sum, input logic en,
		input logic w31, input int gap);
		repeat (gap) @(posedge mclk);
		accOp <= '{1'b1, sel, sum};
		satEnable <= en;
		satWidth31 <= w31;
		@(posedge mclk);
		accOp <= '{1'b0, ~sel, ~sum};
		@(posedge mclk);
	endtask
endmodule

// [dv/test_crs_core_state.sv]
// Self-checking bench for the core register state block
// Assumes the register port and execute strobes of crs_core_state
`timescale 1ns/1ns
module test_crs_core_state;
	import crs_pkg::*;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic mclk = 0, rst = 1, regWr = 0, regRd = 0, wregWr = 0, wregByte = 0;
	logic spAdjust = 0, pcLoad = 0, flagWr = 0, loopActive = 0, rdSeen = 0;
	logic pushShadow = 0, popShadow = 0, loopBegin = 0, loopEnd = 0, satEnable, satWidth31;
	logic catastrophicTrapEnable = 1, arithmeticTrap;
	logic [3:0] wregSel = 0;
	logic [7:0] regAddr = 0, flagLow = 0;
	logic [15:0] regWdata = 0, wregData = 0, spDelta = 0, regRdata, coreStatus;
	logic [15:0] stackPointer, exceptionWord;
	logic [22:0] pcNext = 0, programCounter;
	logic [39:0] accumulatorA, accumulatorB;
	crs_loop_s loopNew = '0, loopRegs, firstLoop;
	crs_accop_s accOp;
	logic [15:0] rdq[$], sv[5];
	logic [31:0] seed = 32'h089BDEB0;
	int errorCnt = 0, samplesChecked = 0, cyc = 0;
	crs_core_state u_dut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .wregWr(wregWr),
		.wregByte(wregByte), .wregSel(wregSel), .wregData(wregData), .spAdjust(spAdjust),
		.spDelta(spDelta), .pcLoad(pcLoad), .pcNext(pcNext), .flagWr(flagWr),
		.flagLow(flagLow), .loopActive(loopActive), .pushShadow(pushShadow),
		.popShadow(popShadow), .loopBegin(loopBegin), .loopEnd(loopEnd), .loopNew(loopNew),
		.accOp(accOp), .satEnable(satEnable), .satWidth31(satWidth31),
		.catastrophicTrapEnable(catastrophicTrapEnable), .coreStatus(coreStatus),
		.programCounter(programCounter), .stackPointer(stackPointer),
		.exceptionWord(exceptionWord), .accumulatorA(accumulatorA),
		.accumulatorB(accumulatorB), .loopRegs(loopRegs), .arithmeticTrap(arithmeticTrap));
	crs_exec_model u_exec (.mclk(mclk), .accOp(accOp), .satEnable(satEnable),
		.satWidth31(satWidth31));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial begin
		forever #10 mclk = ~mclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			errorCnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step();
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		step();
		regWr <= 1'b0;
		step();
	endtask
	// Read note goes on the queue; the monitor compares in the data cycle
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		rdq.push_back(e);
		regAddr <= a;
		regRd <= 1'b1;
		step();
		regRd <= 1'b0;
		step();
	endtask
	always @(posedge mclk) begin
		rdSeen <= regRd;
	end
	always @(negedge mclk) begin
		if (rdSeen) begin
			chk({32'h0, regRdata}, {32'h0, rdq.pop_front()});
		end
	end
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", samplesChecked, errorCnt);
		if (errorCnt == 0 && samplesChecked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			errorCnt++;
			end_of_test();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) step();
		rst <= 1'b0;
		step();
		rd(8'h1E, 16'h0800);
		wr(8'h40, 16'hFFFF);
		rd(8'h40, 16'h0000);
		// Catastrophic mode wraps and requests a trap
		u_exec.issue(1'b0, 41'h0_8000000000, 1'b0, 1'b0, 0);
		@(negedge mclk);
		chk({8'h0, accumulatorA}, 48'h8000000000);
		chk({47'h0, arithmeticTrap}, 48'h1);
		step();
		catastrophicTrapEnable <= 1'b0;
		@(negedge mclk);
		chk({47'h0, arithmeticTrap}, 48'h0);
		step();
		catastrophicTrapEnable <= 1'b1;
		rd(8'h2A, 16'h0080);
		rd(8'h20, 16'hAC00);
		// Bit-31 clamp, then a plain sum keeps the sticky flag
		u_exec.issue(1'b0, 41'h0_0080000000, 1'b1, 1'b1, 2);
		@(negedge mclk);
		chk({8'h0, accumulatorA}, 48'h007FFFFFFF);
		chk({47'h0, arithmeticTrap}, 48'h0);
		step();
		rd(8'h20, 16'h2400);
		u_exec.issue(1'b0, 41'h0_0000000005, 1'b1, 1'b0, 0);
		rd(8'h26, 16'h0005);
		rd(8'h20, 16'h2400);
		wr(8'h20, 16'h0000);
		rd(8'h20, 16'h0000);
		// Bit-39 and bit-31 negative clamps on the second accumulator
		u_exec.issue(1'b1, 41'h1_7FFFFFFFFF, 1'b1, 1'b0, 1);
		rd(8'h2E, 16'h0000);
		rd(8'h30, 16'h0080);
		rd(8'h20, 16'h5C00);
		u_exec.issue(1'b1, 41'h1_FF00000000, 1'b1, 1'b1, 0);
		@(negedge mclk);
		chk({8'h0, accumulatorB}, 48'hFF80000000);
		step();
		rd(8'h20, 16'h1400);
		// Stack pointer alignment and automatic adjust
		wr(8'h1E, 16'h1235);
		rd(8'h1E, 16'h1234);
		spDelta <= 16'h0003;
		spAdjust <= 1'b1;
		step();
		spAdjust <= 1'b0;
		@(negedge mclk);
		chk({32'h0, stackPointer}, 48'h1236);
		step();
		// Shadow push and pop of W0-W3 and five flags
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			sv[i] = seed[15:0];
			wr(8'(2 * i), sv[i]);
		end
		wr(8'h20, 16'h01FF);
		pushShadow <= 1'b1;
		step();
		pushShadow <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			wr(8'(2 * i), ~sv[i]);
		end
		wr(8'h20, 16'h0000);
		popShadow <= 1'b1;
		step();
		popShadow <= 1'b0;
		step();
		for (int i = 0; i < 5; i++) begin
			rd(8'(2 * i), (i < 4) ? sv[i] : ~sv[4]);
		end
		rd(8'h20, 16'h010F);
		// Push directly followed by pop leaves the registers intact
		pushShadow <= 1'b1;
		step();
		pushShadow <= 1'b0;
		popShadow <= 1'b1;
		step();
		popShadow <= 1'b0;
		step();
		rd(8'h00, sv[0]);
		// Byte write keeps the upper byte
		wr(8'h0A, 16'h1234);
		wregWr <= 1'b1;
		wregByte <= 1'b1;
		wregSel <= 4'h5;
		wregData <= 16'hAB77;
		step();
		wregWr <= 1'b0;
		step();
		rd(8'h0A, 16'h1277);
		// Status bytes, program counter and exception word
		flagLow <= 8'hE5;
		flagWr <= 1'b1;
		loopActive <= 1'b1;
		pcNext <= 23'h5ABCDF;
		pcLoad <= 1'b1;
		step();
		flagWr <= 1'b0;
		pcLoad <= 1'b0;
		step();
		@(negedge mclk);
		chk({25'h0, programCounter}, 48'h5ABCDE);
		chk({32'h0, exceptionWord}, 48'hE55A);
		chk({32'h0, coreStatus}, 48'h03E5);
		step();
		rd(8'h20, 16'h03E5);
		rd(8'h24, 16'h005A);
		// Nested loop start restores outer loop registers at end
		firstLoop = '{16'h1110, 16'h2220, 16'h0003};
		loopNew <= firstLoop;
		loopBegin <= 1'b1;
		step();
		loopNew <= '{16'h3330, seed[15:0], 16'h0009};
		step();
		loopBegin <= 1'b0;
		loopEnd <= 1'b1;
		step();
		loopEnd <= 1'b0;
		@(negedge mclk);
		chk({unsigned'(loopRegs)}, {firstLoop});
		step();
		rd(8'h32, 16'h1110);
		// Bit-39 positive clamp on the first accumulator
		u_exec.issue(1'b0, 41'h0_8000000000, 1'b1, 1'b0, 0);
		@(negedge mclk);
		chk({8'h0, accumulatorA}, 48'h7FFFFFFFFF);
		step();
		step();
		end_of_test();
	end
endmodule
